// ---- hall_cal_pkg.sv ----
// Shared constants and carrier types for the threshold calibrator.
// Assumes one clock domain; samples arrive from converter logic on that clock.
package hall_cal_pkg;

    // Sample and bus widths
    localparam int SAMPLE_W = 8;
    localparam int ADDR_W = 4;
    localparam int DATA_W = 32;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_THR_MEM = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_EXTREMES = 4'hc;

    // Field positions
    localparam int CTRL_K_LSB = 0;
    localparam int CTRL_ACT_LSB = 8;
    localparam int MEM_VAL_LSB = 0;
    localparam int MEM_INV_BIT = 8;
    localparam int MEM_PROG_BIT = 9;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_THR_LSB = 8;
    localparam int ST_CNT_LSB = 16;
    localparam int ST_TOOTH_BIT = 24;
    localparam int EXT_MIN_LSB = 0;
    localparam int EXT_MAX_LSB = 8;
    localparam int EXT_UPD_LSB = 16;
    localparam int EXT_RUN_LSB = 24;

    // Reset values
    localparam logic [3:0] K_RESET = 4'h8;
    localparam logic [3:0] K_HALF = 4'h8;
    localparam logic [3:0] ACT_RESET = 4'h2;

    // Signal levels in sample LSBs (one LSB taken as 0.5 mT)
    localparam int HYST_LSB = 4;
    localparam int STEP_LSB = 3;

    // Event counts
    localparam int INIT_PAIRS = 2;
    localparam int PRECAL_MAX_UPD = 32;
    localparam int PRECAL_SWITCHES = 64;
    localparam int CAL_PERIOD = 32;
    localparam int CAL_CONSEC = 4;
    localparam int PLAUS_EXTREMES = 4;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_INIT = 2'b00,
        MODE_PRECAL = 2'b01,
        MODE_CAL = 2'b10
    } mode_t;

    // Register port request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

    // Converter sample
    typedef struct packed {
        logic valid;
        logic [SAMPLE_W-1:0] value;
    } sample_t;

endpackage : hall_cal_pkg

// ---- hall_threshold_calibrator.sv ----
// Switching threshold, mode sequencing and open-drain drive for a tooth/notch switch.
// Assumes samples and register strobes come from logic on clk; no synchronisers needed.
//
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/1ps

// What this block does
// - Threshold memory written once, locked until reset
// - Default: tooth drives low, notch high
// - Polarity bit inverts the output mapping
// - Three modes: initial, precalibrated, calibrated
// - Initial mode compares with visible hysteresis
// - Unprogrammed: load present field as threshold
// - Programmed: compare field against stored value
// - After enough extremes, adjust, enter precalibrated
// - Each min/max pair retunes the threshold
// - Steps of 1.5 mT, 32 updates max
// - Correct in background without switching
// - Precalibrated switching uses hidden arming
// - Unprogrammed uses 50 percent level
// - Level fraction configurable by software
// - After 64 switches enter calibrated
// - Threshold from extremes of 32-switch periods
// - Update after four same-direction periods
// - Direction reversal restarts the four count
// - Adjust only above the activation level
// - Calibrated step at most one LSB
// - Calibrated switching at threshold, hidden arming
// - Power-up always starts in initial mode
// - In calibrated mode, four extremes without switching restart
// - Level is min plus fraction of span
module hall_threshold_calibrator #(
    parameter int HYST = hall_cal_pkg::HYST_LSB,
    parameter int STEP = hall_cal_pkg::STEP_LSB,
    parameter int INIT_PAIRS = hall_cal_pkg::INIT_PAIRS,
    parameter int MAX_UPD = hall_cal_pkg::PRECAL_MAX_UPD,
    parameter int PRECAL_SW = hall_cal_pkg::PRECAL_SWITCHES,
    parameter int PERIOD = hall_cal_pkg::CAL_PERIOD,
    parameter int CONSEC = hall_cal_pkg::CAL_CONSEC,
    parameter int PLAUS = hall_cal_pkg::PLAUS_EXTREMES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire hall_cal_pkg::bus_req_t bus, // Register port request
    input wire hall_cal_pkg::sample_t smp, // Converter sample
    output logic [hall_cal_pkg::DATA_W-1:0] rdata, // Read data, cycle after rd
    output logic q_out, // Open-drain level, only ever low
    output logic q_oe // High while pulling the pin low
);

    localparam int SW = hall_cal_pkg::SAMPLE_W;

    // All state of the block
    typedef struct packed {
        hall_cal_pkg::mode_t mode; // Operating mode
        logic [SW-1:0] thr; // Switching threshold (system offset)
        logic loaded; // Threshold taken after entering initial
        logic tooth; // Output state: strong field seen
        logic armed_up; // Hidden arming for notch-to-tooth
        logic armed_dn; // Hidden arming for tooth-to-notch
        logic phase_up; // Hunting a maximum
        logic [SW-1:0] run_max; // Running maximum
        logic [SW-1:0] run_min; // Running minimum
        logic got_max; // Maximum of current pair found
        logic got_min; // Minimum of current pair found
        logic [SW-1:0] last_max; // Latest maximum event
        logic [SW-1:0] last_min; // Latest minimum event
        logic [2:0] pairs; // Pairs seen in initial mode
        logic [6:0] upd_cnt; // Precalibrated updates used
        logic [6:0] sw_cnt; // Switch events in precalibrated
        logic [6:0] per_cnt; // Switch events in this period
        logic [SW-1:0] abs_max; // Period maximum
        logic [SW-1:0] abs_min; // Period minimum
        logic last_dir; // Direction of last period past the activation level, 1 = up
        logic [3:0] run; // Consecutive same-direction periods
        logic [2:0] ext_cnt; // Extremes since last switch
        logic [SW-1:0] power_on_threshold; // Stored threshold value
        logic mem_inv; // Stored polarity
        logic mem_prog; // Memory has been written
        logic [3:0] k_cfg; // Level fraction in sixteenths
        logic [3:0] act_cfg; // Activation level in LSB
        logic [hall_cal_pkg::DATA_W-1:0] rdata; // Read data
        logic oe; // Pin drive
    } st_t;

    localparam st_t ST_RESET = '{
        mode: hall_cal_pkg::MODE_INIT,
        thr: '0, loaded: 1'b0, tooth: 1'b0,
        armed_up: 1'b1, armed_dn: 1'b1, phase_up: 1'b1,
        run_max: '0, run_min: '1, got_max: 1'b0, got_min: 1'b0,
        last_max: '0, last_min: '0, pairs: '0, upd_cnt: '0,
        sw_cnt: '0, per_cnt: '0, abs_max: '0, abs_min: '0,
        last_dir: 1'b0, run: '0, ext_cnt: '0,
        power_on_threshold: '0, mem_inv: 1'b0, mem_prog: 1'b0,
        k_cfg: hall_cal_pkg::K_RESET, act_cfg: hall_cal_pkg::ACT_RESET,
        rdata: '0, oe: 1'b0
    };

    st_t s_q;
    st_t s_d;

    // Weighted average: max by k, min by 1-k
    function automatic logic [SW-1:0] dyn_level(input logic [SW-1:0] lo,
                                                 input logic [SW-1:0] hi,
                                                 input logic [3:0] k);
        logic [SW-1:0] span;
        logic [SW+3:0] prod;
        span = (hi >= lo) ? hi - lo : '0;
        prod = span * k;
        return lo + prod[SW+3:4];
    endfunction : dyn_level

    // Move cur toward tgt by no more than lim
    function automatic logic [SW-1:0] step_to(input logic [SW-1:0] cur,
                                              input logic [SW-1:0] tgt,
                                              input logic [SW-1:0] lim);
        logic [SW-1:0] res;
        res = tgt;
        if (tgt > cur && (tgt - cur) > lim) begin
            res = cur + lim;
        end else if (cur > tgt && (cur - tgt) > lim) begin
            res = cur - lim;
        end
        return res;
    endfunction : step_to

    // Field clearly above the threshold
    function automatic logic above(input logic [SW-1:0] x, input logic [SW-1:0] t);
        return {1'b0, x} > ({1'b0, t} + (SW+1)'(HYST));
    endfunction : above

    // Field clearly below the threshold
    function automatic logic below(input logic [SW-1:0] x, input logic [SW-1:0] t);
        return ({1'b0, x} + (SW+1)'(HYST)) < {1'b0, t};
    endfunction : below

    // Next-state logic
    always_comb begin
        logic [SW-1:0] x;
        logic ev;
        logic pair;
        logic sw;
        logic [3:0] keff;
        logic [SW-1:0] tgt;
        logic [SW-1:0] mag;
        logic dir;
        logic [3:0] run_n;
        x = smp.value;
        ev = 1'b0;
        pair = 1'b0;
        sw = 1'b0;
        tgt = '0;
        mag = '0;
        dir = 1'b0;
        run_n = '0;
        s_d = s_q;
        s_d.rdata = '0;
        // Unprogrammed parts use the midpoint, else software's fraction
        keff = s_q.mem_prog ? s_q.k_cfg : hall_cal_pkg::K_HALF;

        if (smp.valid) begin
            // Peak hunting, runs in every mode so correction needs no switching
            if (s_q.phase_up) begin
                if (x > s_q.run_max) begin
                    s_d.run_max = x;
                end else if (below(x, s_q.run_max)) begin
                    s_d.got_max = 1'b1;
                    s_d.last_max = s_q.run_max;
                    s_d.phase_up = 1'b0;
                    s_d.run_min = x;
                    ev = 1'b1;
                    pair = s_q.got_min;
                end
            end else begin
                if (x < s_q.run_min) begin
                    s_d.run_min = x;
                end else if (above(x, s_q.run_min)) begin
                    s_d.got_min = 1'b1;
                    s_d.last_min = s_q.run_min;
                    s_d.phase_up = 1'b1;
                    s_d.run_max = x;
                    ev = 1'b1;
                    pair = s_q.got_max;
                end
            end
            if (pair) begin
                s_d.got_max = 1'b0;
                s_d.got_min = 1'b0;
            end

            // Output switching
            if (s_q.mode == hall_cal_pkg::MODE_INIT) begin
                if (!s_q.loaded) begin
                    // Stored value if present, else the field itself
                    s_d.thr = s_q.mem_prog ? s_q.power_on_threshold : x;
                    s_d.loaded = 1'b1;
                end else if (!s_q.tooth && above(x, s_q.thr)) begin
                    s_d.tooth = 1'b1;
                end else if (s_q.tooth && below(x, s_q.thr)) begin
                    s_d.tooth = 1'b0;
                end
            end else begin
                // Hidden arming: no visible hysteresis, noise cannot chatter
                if (below(x, s_q.thr)) begin
                    s_d.armed_up = 1'b1;
                end
                if (above(x, s_q.thr)) begin
                    s_d.armed_dn = 1'b1;
                end
                if (!s_q.tooth && s_q.armed_up && x > s_q.thr) begin
                    s_d.tooth = 1'b1;
                    s_d.armed_up = 1'b0;
                end else if (s_q.tooth && s_q.armed_dn && x < s_q.thr) begin
                    s_d.tooth = 1'b0;
                    s_d.armed_dn = 1'b0;
                end
            end
            sw = s_d.tooth != s_q.tooth;

            // Mode bookkeeping
            unique case (s_q.mode)
                hall_cal_pkg::MODE_INIT: begin
                    if (pair && s_q.loaded) begin
                        if (s_q.pairs == 3'(INIT_PAIRS - 1)) begin
                            // Enough extremes: retune and move on
                            s_d.thr = dyn_level(s_d.last_min, s_d.last_max, keff);
                            s_d.mode = hall_cal_pkg::MODE_PRECAL;
                            s_d.upd_cnt = '0;
                            s_d.sw_cnt = '0;
                            s_d.armed_up = 1'b1;
                            s_d.armed_dn = 1'b1;
                        end else begin
                            s_d.pairs = s_q.pairs + 3'h1;
                        end
                    end
                end
                hall_cal_pkg::MODE_PRECAL: begin
                    // One bounded step per pair; the budget caps total drift
                    if (pair && s_q.upd_cnt < 7'(MAX_UPD)) begin
                        tgt = dyn_level(s_d.last_min, s_d.last_max, keff);
                        s_d.thr = step_to(s_q.thr, tgt, SW'(STEP));
                        s_d.upd_cnt = s_q.upd_cnt + 7'h01;
                    end
                    if (sw) begin
                        if (s_q.sw_cnt == 7'(PRECAL_SW - 1)) begin
                            s_d.mode = hall_cal_pkg::MODE_CAL;
                            s_d.per_cnt = '0;
                            s_d.abs_min = x;
                            s_d.abs_max = x;
                            s_d.run = '0;
                            s_d.ext_cnt = '0;
                        end else begin
                            s_d.sw_cnt = s_q.sw_cnt + 7'h01;
                        end
                    end
                end
                hall_cal_pkg::MODE_CAL: begin
                    // Absolute extremes over the period
                    if (x > s_q.abs_max) begin
                        s_d.abs_max = x;
                    end
                    if (x < s_q.abs_min) begin
                        s_d.abs_min = x;
                    end
                    if (sw && s_q.per_cnt == 7'(PERIOD - 1)) begin
                        tgt = dyn_level(s_d.abs_min, s_d.abs_max, keff);
                        dir = tgt > s_q.thr;
                        mag = dir ? tgt - s_q.thr : s_q.thr - tgt;
                        if (mag > SW'(s_q.act_cfg)) begin
                            // Same direction extends the run, reversal restarts it
                            if (s_q.run != 4'h0 && dir == s_q.last_dir) begin
                                run_n = (s_q.run == 4'hf) ? s_q.run : s_q.run + 4'h1;
                            end else begin
                                run_n = 4'h1;
                            end
                            s_d.last_dir = dir;
                            if (run_n >= 4'(CONSEC)) begin
                                s_d.thr = dir ? s_q.thr + SW'(1) : s_q.thr - SW'(1);
                            end
                        end else begin
                            run_n = '0;
                        end
                        s_d.run = run_n;
                        s_d.per_cnt = '0;
                        s_d.abs_min = x;
                        s_d.abs_max = x;
                    end else if (sw) begin
                        s_d.per_cnt = s_q.per_cnt + 7'h01;
                    end
                    // Plausibility: activity with no switching means we are lost
                    if (sw) begin
                        s_d.ext_cnt = '0;
                    end else if (ev) begin
                        if (s_q.ext_cnt == 3'(PLAUS - 1)) begin
                            s_d.mode = hall_cal_pkg::MODE_INIT;
                            s_d.loaded = 1'b0;
                            s_d.pairs = '0;
                            s_d.got_max = 1'b0;
                            s_d.got_min = 1'b0;
                            s_d.ext_cnt = '0;
                        end else begin
                            s_d.ext_cnt = s_q.ext_cnt + 3'h1;
                        end
                    end
                end
                default: begin
                    s_d.mode = hall_cal_pkg::MODE_INIT;
                end
            endcase
        end

        // Register writes
        if (bus.wr) begin
            if (bus.addr == hall_cal_pkg::ADDR_CTRL) begin
                s_d.k_cfg = bus.wdata[hall_cal_pkg::CTRL_K_LSB +: 4];
                s_d.act_cfg = bus.wdata[hall_cal_pkg::CTRL_ACT_LSB +: 4];
            end else if (bus.addr == hall_cal_pkg::ADDR_THR_MEM && !s_q.mem_prog) begin
                // Write-once: later writes are ignored until reset
                s_d.power_on_threshold = bus.wdata[hall_cal_pkg::MEM_VAL_LSB +: SW];
                s_d.mem_inv = bus.wdata[hall_cal_pkg::MEM_INV_BIT];
                s_d.mem_prog = 1'b1;
            end
        end

        // Register reads, answered the next cycle
        if (bus.rd) begin
            unique case (bus.addr)
                hall_cal_pkg::ADDR_CTRL: begin
                    s_d.rdata[hall_cal_pkg::CTRL_K_LSB +: 4] = s_q.k_cfg;
                    s_d.rdata[hall_cal_pkg::CTRL_ACT_LSB +: 4] = s_q.act_cfg;
                end
                hall_cal_pkg::ADDR_THR_MEM: begin
                    s_d.rdata[hall_cal_pkg::MEM_VAL_LSB +: SW] = s_q.power_on_threshold;
                    s_d.rdata[hall_cal_pkg::MEM_INV_BIT] = s_q.mem_inv;
                    s_d.rdata[hall_cal_pkg::MEM_PROG_BIT] = s_q.mem_prog;
                end
                hall_cal_pkg::ADDR_STATUS: begin
                    s_d.rdata[hall_cal_pkg::ST_MODE_LSB +: 2] = s_q.mode;
                    s_d.rdata[hall_cal_pkg::ST_THR_LSB +: SW] = s_q.thr;
                    s_d.rdata[hall_cal_pkg::ST_CNT_LSB +: 7] = s_q.sw_cnt;
                    s_d.rdata[hall_cal_pkg::ST_TOOTH_BIT] = s_q.tooth;
                end
                hall_cal_pkg::ADDR_EXTREMES: begin
                    s_d.rdata[hall_cal_pkg::EXT_MIN_LSB +: SW] = s_q.last_min;
                    s_d.rdata[hall_cal_pkg::EXT_MAX_LSB +: SW] = s_q.last_max;
                    s_d.rdata[hall_cal_pkg::EXT_UPD_LSB +: 7] = s_q.upd_cnt;
                    s_d.rdata[hall_cal_pkg::EXT_RUN_LSB +: 4] = s_q.run;
                end
                default: begin
                    s_d.rdata = '0; // Unmapped reads as zero
                end
            endcase
        end

        // Tooth pulls low unless the polarity bit flips it
        s_d.oe = s_d.tooth ^ s_d.mem_inv;
    end

    // State register; power-up lands in initial mode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= ST_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata = s_q.rdata;
    assign q_oe = s_q.oe;
    assign q_out = 1'b0; // Open drain only ever pulls low

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    // Once written, the stored value never changes
    property p_mem_once;
        s_q.mem_prog |=> s_q.mem_prog && $stable(s_q.power_on_threshold) && $stable(s_q.mem_inv);
    endproperty
    a_mem_once: assert property (p_mem_once) else $error("threshold memory rewritten");

    // Pin drive follows tooth and polarity
    property p_polarity;
        s_q.oe == (s_q.tooth ^ s_q.mem_inv);
    endproperty
    a_polarity: assert property (p_polarity) else $error("pin drive wrong");

    // Modes only advance, except the plausibility restart from calibrated
    property p_mode_order;
        $past(s_q.mode) == hall_cal_pkg::MODE_PRECAL |-> s_q.mode != hall_cal_pkg::MODE_INIT;
    endproperty
    a_mode_order: assert property (p_mode_order) else $error("mode went backwards");

    // Precalibrated entry starts with fresh counters
    property p_precal_entry;
        $past(s_q.mode) == hall_cal_pkg::MODE_INIT && s_q.mode == hall_cal_pkg::MODE_PRECAL
            |-> s_q.upd_cnt == 7'h00 && s_q.sw_cnt == 7'h00 && $past(s_q.pairs) == 3'(INIT_PAIRS - 1);
    endproperty
    a_precal_entry: assert property (p_precal_entry) else $error("bad precal entry");

    // Precalibrated steps bounded, budget never exceeded
    property p_precal_step;
        $past(s_q.mode) == hall_cal_pkg::MODE_PRECAL && s_q.mode == hall_cal_pkg::MODE_PRECAL
            |-> s_q.upd_cnt <= 7'(MAX_UPD)
                && ((s_q.thr >= $past(s_q.thr)) ? (s_q.thr - $past(s_q.thr))
                    : ($past(s_q.thr) - s_q.thr)) <= SW'(STEP);
    endproperty
    a_precal_step: assert property (p_precal_step) else $error("precal step too big");

    // Calibrated entry only after the switch count completes
    property p_cal_entry;
        $past(s_q.mode) == hall_cal_pkg::MODE_PRECAL && s_q.mode == hall_cal_pkg::MODE_CAL
            |-> $past(s_q.sw_cnt) == 7'(PRECAL_SW - 1) && $past(s_q.tooth) != s_q.tooth;
    endproperty
    a_cal_entry: assert property (p_cal_entry) else $error("early calibrated entry");

    // Calibrated threshold moves by one LSB and only after a full run
    property p_cal_move;
        s_q.mode == hall_cal_pkg::MODE_CAL ##1 s_q.mode == hall_cal_pkg::MODE_CAL && !$stable(s_q.thr)
            |-> s_q.run >= 4'(CONSEC) && s_q.per_cnt == 7'h00
                && (s_q.thr == $past(s_q.thr) + SW'(1) || s_q.thr == $past(s_q.thr) - SW'(1));
    endproperty
    a_cal_move: assert property (p_cal_move) else $error("calibrated update illegal");

    // Hidden arming: a tooth switch needs prior arming and clears it
    property p_hidden_arm;
        s_q.mode != hall_cal_pkg::MODE_INIT && !s_q.tooth ##1 s_q.tooth
            |-> $past(s_q.armed_up) && !s_q.armed_up;
    endproperty
    a_hidden_arm: assert property (p_hidden_arm) else $error("unarmed switch");

endmodule : hall_threshold_calibrator

// ---- field_source.sv ----
// Model of the field front end and of the pulled-up switch line.
// Assumes clk from the bench; one converter sample per cycle while run is high.
`timescale 1ns/1ps
module field_source (
    input wire logic clk,
    input wire logic run, // Sampling active
    input wire logic [7:0] field, // Present field level
    input wire logic q_oe, // Switch pulls the line low
    output hall_cal_pkg::sample_t smp, // Sample toward the switch
    output logic line // Line level seen by the controller
);
    // Pull-up: a released line reads high, never a held value
    assign line = q_oe ? 1'b0 : 1'b1;
    // Converter registers one sample per cycle, like the real front end
    always @(posedge clk) begin
        smp <= '{valid: run, value: field};
    end
endmodule : field_source

// ---- testbench.sv ----
// Self-checking bench for the threshold calibrator with the field source.
// Assumes shortened switch counts set at the instance below.
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
    $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module testbench;
    logic clk; // 125 MHz clock
    logic arst_n; // Async reset, active low
    hall_cal_pkg::bus_req_t bus; // Register request
    hall_cal_pkg::sample_t smp; // Sample from the source
    logic [31:0] rdata; // Read data
    logic q_oe; // Pin pull enable
    logic q_out; // Open-drain pin level
    logic line; // Line level
    logic run; // Source running
    logic [7:0] field; // Field level to send
    logic [31:0] d; // Last read word
    int failures = 0; // Mismatches
    int compares = 0; // Comparisons
    // Short counts keep the mode walk brief
    hall_threshold_calibrator #(.PRECAL_SW(8), .PERIOD(4)) u_dut (.clk(clk), .arst_n(arst_n),
        .bus(bus), .smp(smp), .rdata(rdata), .q_out(q_out), .q_oe(q_oe));
    field_source u_src (.clk(clk), .run(run), .field(field), .q_oe(q_oe), .smp(smp),
        .line(line));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic final_report();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : final_report
    // Every bus task starts on an edge, so strobes never collide
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus <= '0;
    endtask : wr
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus <= '0;
        #1;
        d = rdata;
    endtask : rd
    // Hold one level for six samples; ends at a falling edge, line settled
    task automatic feed(input logic [7:0] v);
        @(posedge clk);
        field <= v;
        run <= 1'b1;
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask : feed
    // Tooth and notch levels in turn
    task automatic wave(input logic [7:0] hi, input logic [7:0] lo, input int n);
        repeat (n) begin
            feed(hi);
            feed(lo);
        end
    endtask : wave
    task automatic do_reset();
        @(posedge clk);
        arst_n <= 1'b0;
        run <= 1'b0;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
    endtask : do_reset
    task automatic t_reset();
        do_reset();
        rd(4'h0);
        `CHK(d, 32'h0000_0208)
        `CHK(q_out, 1'b0)
        rd(4'h8);
        `CHK(d[1:0], 2'h0)
        rd(4'h2);
        `CHK(d, 32'h0)
        wr(4'h0, 32'h0000_0304);
        rd(4'h0);
        `CHK(d, 32'h0000_0304)
        feed(8'h50);
        rd(4'h8);
        `CHK(d[15:8], 8'h50)
    endtask : t_reset
    task automatic t_prog();
        do_reset();
        wr(4'h4, 32'h0000_0064);
        wr(4'h4, 32'h0000_01ff);
        rd(4'h4);
        `CHK(d, 32'h0000_0264)
        feed(8'h32);
        rd(4'h8);
        `CHK(d[15:8], 8'h64)
        feed(8'h6e);
        `CHK(line, 1'b0)
        feed(8'h66);
        `CHK(line, 1'b0)
        feed(8'h5a);
        `CHK(line, 1'b1)
    endtask : t_prog
    task automatic t_inv();
        do_reset();
        wr(4'h4, 32'h0000_0164);
        feed(8'h6e);
        feed(8'h6e);
        `CHK(line, 1'b1)
        feed(8'h5a);
        `CHK(line, 1'b0)
    endtask : t_inv
    // Walk initial, precalibrated, calibrated, then the stuck-output restart
    task automatic t_modes();
        do_reset();
        wr(4'h4, 32'h0000_0050);
        wave(8'h78, 8'h28, 3);
        rd(4'h8);
        `CHK(d[1:0], 2'h1)
        `CHK(d[15:8], 8'h50)
        rd(4'hc);
        `CHK(d, 32'h0000_7828)
        wr(4'h0, 32'h0000_020c);
        wave(8'h78, 8'h28, 2);
        rd(4'h8);
        `CHK((d[15:8] inside {8'h53, 8'h56, 8'h59}), 1'b1)
        rd(4'hc);
        `CHK(d[22:16], 7'h02)
        wave(8'h78, 8'h28, 12);
        rd(4'h8);
        `CHK(d[1:0], 2'h2)
        `CHK(d[15:8], 8'h5e)
        rd(4'hc);
        `CHK(d, 32'h0504_7828)
        wave(8'h96, 8'h8c, 4);
        rd(4'h8);
        `CHK(d[1:0], 2'h0)
    endtask : t_modes
    initial begin
        arst_n = 1'b0;
        bus = '0;
        run = 1'b0;
        field = 8'h0;
        t_reset();
        t_prog();
        t_inv();
        t_modes();
        final_report();
    end
    // Watchdog well beyond the few hundred cycles of the tests
    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        final_report();
    end
endmodule : testbench
